// ==== design/flash_access_protection.sv ====
// Flash access protection: APB registers, zone check, command sequencer and read guard
//
// Notes on behaviour
// - Data register reads last read byte, writes hold byte to program.
// - Low address register holds address bits 7..0, read/write, resets zero.
// - High address register holds address bits 15..8, read/write, resets zero.
// - Each erase and write command is checked against protection zones; hit aborts with failure.
// - Two zones: bottom from address zero, top up to the last address.
// - Zone bounds count in 256-byte pages.
// - Bottom zone covers pages below bottom bound minus one.
// - Top zone covers pages above top bound plus one.
// - Bottom bound resets to all ones; software must lower it first.
// - Top bound resets to zero; software loads it from stored configuration.
// - Read guard only spans addresses 0x01000 through 0x0FFFF.
// - Every reset clears both read guard enable registers.
// - Guard enables are set-only: ones set, zeros leave bits alone.
// - Only a reset clears a set guard enable bit.
// - Guarded program loads and controller reads return zero.
// - Guarded instruction fetches receive zero, executed as no-operation.
// - Bit n guards from boundary n+1; lowest set bit sets start.
// - Guard enable writes need the timed write unlock.
// - Command address is top, high and low address registers joined.
// - Only erase and write are zone checked; failures never execute.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "flash_access_protection_defs.svh"

module flash_access_protection
	import flash_access_protection_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Write unlock window from the system
	input wire logic timed_write_unlock,
	// Flash array port
	output logic flash_req,
	output logic [1:0] flash_op,
	output logic [16:0] flash_addr,
	output logic [7:0] flash_wdata,
	input wire logic flash_ack,
	input wire logic [7:0] flash_rdata,
	// Program load and fetch port
	input wire logic [16:0] code_addr,
	input wire logic [7:0] code_raw,
	output logic [7:0] code_data
);

	regs_type q;
	regs_type next_q;

	guard_check_if gif();

	logic [15:0] index;
	logic setup;
	logic access;
	logic wr;
	logic [7:0] wbyte;
	logic [8:0] page;
	logic low_hit;
	logic high_hit;
	logic zone_hit;
	logic cmd_write;
	logic mapped;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	assign index = paddr[17:2];
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr = access && pwrite;
	assign wbyte = pwdata[7:0];
	assign cmd_write = wr && index == `IDX_COMMAND;

	always_comb begin
		unique case (index)
			`IDX_ADDR_TOP, `IDX_GUARD_LO, `IDX_GUARD_HI, `IDX_COMMAND, `IDX_DATA,
			`IDX_ADDR_HIGH, `IDX_ADDR_LOW, `IDX_BOUND_LO, `IDX_BOUND_HI,
			`IDX_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// ****************************************************************
	// Zone check
	// ****************************************************************
	// Page number is the address above bit seven
	assign page = {q.addr_top[0], q.addr_high};
	// Bound of zero leaves the bottom zone empty instead of wrapping
	assign low_hit = q.bound_lo != 8'h00 &&
		{1'b0, page} < ({2'h0, q.bound_lo} - 10'h001);
	assign high_hit = {1'b0, page} > ({2'h0, q.bound_hi} + 10'h001);
	assign zone_hit = low_hit || high_hit;

	// ****************************************************************
	// Read guard checker
	// ****************************************************************
	assign gif.enables = {q.guard_hi, q.guard_lo};
	assign gif.ctl_addr = flash_addr;
	assign gif.ctl_raw = flash_rdata;
	assign gif.code_addr = code_addr;
	assign gif.code_raw = code_raw;

	read_guard_check guard (
		.gif(gif)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_q = q;

		// Read data is latched in the setup phase and shown in the access phase
		if (setup) begin
			next_q.err = !mapped;
			unique case (index)
				`IDX_ADDR_TOP: next_q.rdata = q.addr_top;
				`IDX_GUARD_LO: next_q.rdata = q.guard_lo;
				`IDX_GUARD_HI: next_q.rdata = {1'b0, q.guard_hi};
				`IDX_DATA: next_q.rdata = q.data_rd;
				`IDX_ADDR_HIGH: next_q.rdata = q.addr_high;
				`IDX_ADDR_LOW: next_q.rdata = q.addr_low;
				`IDX_BOUND_LO: next_q.rdata = q.bound_lo;
				`IDX_BOUND_HI: next_q.rdata = q.bound_hi;
				`IDX_STATUS: begin
					next_q.rdata = `RST_BYTE;
					next_q.rdata[`STAT_BUSY_BIT] = q.fsm == st_run;
					next_q.rdata[`STAT_FAIL_BIT] = q.fail;
					next_q.rdata[`STAT_DONE_BIT] = q.done;
				end
				default: next_q.rdata = `RST_BYTE;
			endcase
		end

		if (wr) begin
			unique case (index)
				`IDX_ADDR_TOP: next_q.addr_top = wbyte;
				`IDX_DATA: next_q.data_wr = wbyte;
				`IDX_ADDR_HIGH: next_q.addr_high = wbyte;
				`IDX_ADDR_LOW: next_q.addr_low = wbyte;
				`IDX_BOUND_LO: next_q.bound_lo = wbyte;
				`IDX_BOUND_HI: next_q.bound_hi = wbyte;
				`IDX_GUARD_LO: begin
					if (timed_write_unlock) begin
						next_q.guard_lo = q.guard_lo | wbyte;
					end
				end
				`IDX_GUARD_HI: begin
					if (timed_write_unlock) begin
						next_q.guard_hi = q.guard_hi | wbyte[6:0];
					end
				end
				default: begin
				end
			endcase
		end

		unique case (q.fsm)
			st_idle: begin
				// Commands arriving while busy are ignored
				if (cmd_write && wbyte[2:0] != 3'h0) begin
					next_q.fail = 1'b0;
					next_q.done = 1'b0;
					if (wbyte[`CMD_READ_BIT]) begin
						next_q.op = `OP_READ;
						next_q.fsm = st_run;
					end else if (zone_hit) begin
						next_q.fail = 1'b1;
						next_q.done = 1'b1;
					end else begin
						next_q.op = wbyte[`CMD_ERASE_BIT] ? `OP_ERASE : `OP_WRITE;
						next_q.fsm = st_run;
					end
				end
			end
			st_run: begin
				if (flash_ack) begin
					next_q.fsm = st_idle;
					next_q.done = 1'b1;
					if (q.op == `OP_READ) begin
						next_q.data_rd = gif.ctl_data;
					end
				end
			end
		endcase

		next_q.code_data = gif.code_data;
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			q.fsm <= st_idle;
			q.addr_low <= `RST_BYTE;
			q.addr_high <= `RST_BYTE;
			q.addr_top <= `RST_BYTE;
			q.data_wr <= `RST_BYTE;
			q.data_rd <= `RST_BYTE;
			q.bound_lo <= `RST_BOUND_LO;
			q.bound_hi <= `RST_BOUND_HI;
			q.guard_lo <= `RST_BYTE;
			q.guard_hi <= `RST_GUARD_HI;
			q.op <= `OP_READ;
			q.fail <= 1'b0;
			q.done <= 1'b0;
			q.rdata <= `RST_BYTE;
			q.err <= 1'b0;
			q.code_data <= `RST_BYTE;
		end else begin
			q <= next_q;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata = {24'h00_0000, q.rdata};
	assign pready = 1'b1;
	assign pslverr = access && q.err;
	assign flash_req = q.fsm == st_run;
	assign flash_op = q.op;
	assign flash_addr = {q.addr_top[0], q.addr_high, q.addr_low};
	assign flash_wdata = q.data_wr;
	assign code_data = q.code_data;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_bound_lo_reset: assert property (@(posedge clock)
		!$past(reset_n) && reset_n |-> q.bound_lo == 8'hff)
		else $error("bottom bound not all ones after reset");

	a_bound_hi_reset: assert property (@(posedge clock)
		!$past(reset_n) && reset_n |-> q.bound_hi == 8'h00)
		else $error("top bound not zero after reset");

	a_guard_cleared: assert property (@(posedge clock)
		!$past(reset_n) && reset_n |-> q.guard_lo == 8'h00 && q.guard_hi == 7'h00)
		else $error("guard enables not cleared by reset");

	a_guard_sticky: assert property (@(posedge clock) disable iff (!reset_n)
		$past(reset_n) |-> ((q.guard_lo & $past(q.guard_lo)) == $past(q.guard_lo)) &&
		((q.guard_hi & $past(q.guard_hi)) == $past(q.guard_hi)))
		else $error("guard enable bit cleared without reset");

	a_guard_unlock: assert property (@(posedge clock) disable iff (!reset_n)
		wr && !timed_write_unlock && index == `IDX_GUARD_LO |=> $stable(q.guard_lo))
		else $error("guard enable changed without unlock");

	a_guard_set_only: assert property (@(posedge clock) disable iff (!reset_n)
		wr && timed_write_unlock && index == `IDX_GUARD_LO
		|=> q.guard_lo == ($past(q.guard_lo) | $past(wbyte)))
		else $error("guard enable write not set-only");

	a_zone_abort: assert property (@(posedge clock) disable iff (!reset_n)
		q.fsm == st_idle && cmd_write && !wbyte[`CMD_READ_BIT] && wbyte[2:1] != 2'h0 &&
		zone_hit |=> q.fail && q.done && !flash_req [*2])
		else $error("protected command not aborted");

	a_zone_pass: assert property (@(posedge clock) disable iff (!reset_n)
		q.fsm == st_idle && cmd_write && wbyte[`CMD_READ_BIT] |=> flash_req && !q.fail)
		else $error("read command blocked by zone check");

	a_read_blank: assert property (@(posedge clock) disable iff (!reset_n)
		flash_req && flash_op == `OP_READ && flash_ack && gif.ctl_hit |=> q.data_rd == 8'h00)
		else $error("guarded controller read not blanked");

	a_fetch_blank: assert property (@(posedge clock) disable iff (!reset_n)
		gif.code_hit |=> code_data == 8'h00)
		else $error("guarded fetch not blanked");

	a_fetch_pass: assert property (@(posedge clock) disable iff (!reset_n)
		code_addr > 17'h0_ffff || code_addr < 17'h0_1000 |=> code_data == $past(code_raw))
		else $error("fetch outside guard range altered");

	a_addr_low_write: assert property (@(posedge clock) disable iff (!reset_n)
		wr && index == `IDX_ADDR_LOW |=> flash_addr[7:0] == $past(wbyte))
		else $error("low address write lost");

	a_addr_high_write: assert property (@(posedge clock) disable iff (!reset_n)
		wr && index == `IDX_ADDR_HIGH |=> flash_addr[15:8] == $past(wbyte))
		else $error("high address write lost");

	a_addr_top_write: assert property (@(posedge clock) disable iff (!reset_n)
		wr && index == `IDX_ADDR_TOP |=> flash_addr[16] == $past(wbyte[0]))
		else $error("top address bit not taken from top address register");

	a_data_write: assert property (@(posedge clock) disable iff (!reset_n)
		wr && index == `IDX_DATA |=> flash_wdata == $past(wbyte))
		else $error("program byte write lost");

	a_guard_hi_unlock: assert property (@(posedge clock) disable iff (!reset_n)
		wr && !timed_write_unlock && index == `IDX_GUARD_HI |=> $stable(q.guard_hi))
		else $error("upper guard enable changed without unlock");

	a_guard_hi_set: assert property (@(posedge clock) disable iff (!reset_n)
		wr && timed_write_unlock && index == `IDX_GUARD_HI
		|=> q.guard_hi == ($past(q.guard_hi) | $past(wbyte[6:0])))
		else $error("upper guard enable write not set-only");

	a_read_capture: assert property (@(posedge clock) disable iff (!reset_n)
		flash_req && flash_op == `OP_READ && flash_ack && q.guard_lo == 8'h00 &&
		q.guard_hi == 7'h00 |=> q.data_rd == $past(flash_rdata))
		else $error("unguarded read byte not kept");

	a_ctl_outside: assert property (@(posedge clock) disable iff (!reset_n)
		flash_req && flash_op == `OP_READ && flash_ack &&
		(flash_addr < 17'h0_1000 || flash_addr > 17'h0_ffff) |=> q.data_rd == $past(flash_rdata))
		else $error("controller read outside guard range altered");

	a_guard_lo_start: assert property (@(posedge clock) disable iff (!reset_n)
		q.guard_lo[5] && code_addr >= 17'h0_6000 && code_addr <= 17'h0_ffff
		|=> code_data == 8'h00)
		else $error("lower guard enable start boundary not blanked");

	a_guard_hi_start: assert property (@(posedge clock) disable iff (!reset_n)
		q.guard_hi[2] && code_addr >= 17'h0_b000 && code_addr <= 17'h0_ffff
		|=> code_data == 8'h00)
		else $error("upper guard enable start boundary not blanked");

	a_guard_below: assert property (@(posedge clock) disable iff (!reset_n)
		q.guard_lo[4:0] == 5'h00 && code_addr < 17'h0_6000 |=> code_data == $past(code_raw))
		else $error("fetch below guard start altered");

	a_guard_off: assert property (@(posedge clock) disable iff (!reset_n)
		q.guard_lo == 8'h00 && q.guard_hi == 7'h00 |=> code_data == $past(code_raw))
		else $error("fetch altered with guard off");

	a_zone_run: assert property (@(posedge clock) disable iff (!reset_n)
		q.fsm == st_idle && cmd_write && !wbyte[`CMD_READ_BIT] && wbyte[2:1] != 2'h0 &&
		!zone_hit |=> flash_req && !q.fail)
		else $error("unprotected command not started");

	a_req_end: assert property (@(posedge clock) disable iff (!reset_n)
		flash_req && flash_ack |=> !flash_req && q.done)
		else $error("command not finished on acknowledge");

	a_reset_lock: assert property (@(posedge clock) disable iff (!reset_n)
		q.fsm == st_idle && cmd_write && !wbyte[`CMD_READ_BIT] && wbyte[2:1] != 2'h0 &&
		q.bound_lo == 8'hff && flash_addr[16:8] < 9'h0fe |=> q.fail && !flash_req)
		else $error("command not refused with bottom bound at reset value");

endmodule

`default_nettype wire

// ==== design/flash_access_protection_defs.svh ====
// Register map, field layout, reset values and encodings of the flash protection block
`ifndef FLASH_ACCESS_PROTECTION_DEFS_SVH
`define FLASH_ACCESS_PROTECTION_DEFS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_ADDR_TOP 16'ha012
`define IDX_GUARD_LO 16'ha013
`define IDX_GUARD_HI 16'ha014
`define IDX_COMMAND 16'ha020
`define IDX_DATA 16'ha021
`define IDX_ADDR_HIGH 16'ha022
`define IDX_ADDR_LOW 16'ha023
`define IDX_BOUND_LO 16'ha025
`define IDX_BOUND_HI 16'ha026
`define IDX_STATUS 16'ha027

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_BYTE 8'h00
`define RST_BOUND_LO 8'hff
`define RST_BOUND_HI 8'h00
`define RST_GUARD_HI 7'h00

// ****************************************************************
// Command and status fields
// ****************************************************************
`define CMD_READ_BIT 0
`define CMD_ERASE_BIT 1
`define CMD_WRITE_BIT 2
`define OP_READ 2'h0
`define OP_ERASE 2'h1
`define OP_WRITE 2'h2
`define STAT_BUSY_BIT 0
`define STAT_FAIL_BIT 1
`define STAT_DONE_BIT 2

// ****************************************************************
// Read guard geometry
// ****************************************************************
`define GUARD_BITS 15
`define GUARD_TOP 17'h0_ffff
`define GUARD_STEP_SHIFT 12

`endif

// ==== design/flash_access_protection_pkg.sv ====
// Types shared by the flash protection block
`include "flash_access_protection_defs.svh"

package flash_access_protection_pkg;

	typedef enum logic {
		st_idle,
		st_run
	} state_type;

	typedef struct packed {
		state_type fsm;
		logic [7:0] addr_low;
		logic [7:0] addr_high;
		logic [7:0] addr_top;
		logic [7:0] data_wr;
		logic [7:0] data_rd;
		logic [7:0] bound_lo;
		logic [7:0] bound_hi;
		logic [7:0] guard_lo;
		logic [6:0] guard_hi;
		logic [1:0] op;
		logic fail;
		logic done;
		logic [7:0] rdata;
		logic err;
		logic [7:0] code_data;
	} regs_type;

endpackage

// ==== design/guard_check_if.sv ====
// Signals between the protection core and its read guard checker
`timescale 1ns/1ps
`default_nettype none

interface guard_check_if;
	logic [14:0] enables;
	logic [16:0] ctl_addr;
	logic [7:0] ctl_raw;
	logic [7:0] ctl_data;
	logic ctl_hit;
	logic [16:0] code_addr;
	logic [7:0] code_raw;
	logic [7:0] code_data;
	logic code_hit;

	modport core (
		output enables, ctl_addr, ctl_raw, code_addr, code_raw,
		input ctl_data, ctl_hit, code_data, code_hit
	);
	modport checker_side (
		input enables, ctl_addr, ctl_raw, code_addr, code_raw,
		output ctl_data, ctl_hit, code_data, code_hit
	);
endinterface

`default_nettype wire

// ==== design/read_guard_check.sv ====
// Read guard: finds the guarded start and blanks reads inside the guarded range
`timescale 1ns/1ps
`default_nettype none
`include "flash_access_protection_defs.svh"

module read_guard_check
	import flash_access_protection_pkg::*;
(
	// Core side
	guard_check_if.checker_side gif
);

	logic [16:0] start;
	logic any_set;

	// ****************************************************************
	// Lowest set enable bit selects the start boundary
	// ****************************************************************
	always_comb begin
		start = `GUARD_TOP;
		any_set = 1'b0;
		for (int n = `GUARD_BITS - 1; n >= 0; n--) begin
			if (gif.enables[n]) begin
				any_set = 1'b1;
				start = 17'((n + 1) << `GUARD_STEP_SHIFT);
			end
		end
	end

	assign gif.ctl_hit = any_set && gif.ctl_addr >= start && gif.ctl_addr <= `GUARD_TOP;
	assign gif.code_hit = any_set && gif.code_addr >= start && gif.code_addr <= `GUARD_TOP;
	assign gif.ctl_data = gif.ctl_hit ? `RST_BYTE : gif.ctl_raw;
	assign gif.code_data = gif.code_hit ? `RST_BYTE : gif.code_raw;

endmodule

`default_nettype wire

// ==== tb/flash_array_model.sv ====
// Behavioural flash array answering commands after a delay and serving code bytes
`timescale 1ns/1ps
`default_nettype none

module flash_array_model #(
	parameter int LATENCY = 3
) (
	// Clock
	input wire logic clock,
	// Command port
	input wire logic flash_req,
	input wire logic [1:0] flash_op,
	input wire logic [16:0] flash_addr,
	output logic flash_ack,
	output logic [7:0] flash_rdata,
	// Code port
	input wire logic [16:0] code_addr,
	output logic [7:0] code_raw,
	// Last command served
	output logic [1:0] last_op,
	output logic [16:0] last_addr
);
	int wait_count = 0;

	function automatic logic [7:0] pattern(input logic [16:0] a);
		return a[7:0] ^ a[15:8] ^ {7'h00, a[16]} ^ 8'ha5;
	endfunction

	initial begin
		flash_ack = 1'b0;
		flash_rdata = 8'h00;
	end

	always @(posedge clock) begin
		flash_ack <= 1'b0;
		// Read data is only meaningful beside the acknowledge
		flash_rdata <= ~flash_rdata;
		if (flash_req === 1'b1 && !flash_ack) begin
			if (wait_count == LATENCY) begin
				wait_count <= 0;
				flash_ack <= 1'b1;
				flash_rdata <= pattern(flash_addr);
				last_op <= flash_op;
				last_addr <= flash_addr;
			end else begin
				wait_count <= wait_count + 1;
			end
		end
	end

	assign code_raw = pattern(code_addr);
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking testbench of the flash access protection block
`timescale 1ns/1ps
`default_nettype none
`include "flash_access_protection_defs.svh"

module tb
	import flash_access_protection_pkg::*;
;
	typedef struct {logic [15:0] idx; logic [7:0] rst; logic [7:0] wd; logic [7:0] exp;} row_type;
	typedef struct {logic [16:0] a; logic [7:0] c; logic f;} zone_type;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic timed_write_unlock = 1'b0;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [16:0] code_addr = '0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, flash_req, flash_ack;
	logic [1:0] flash_op, last_op;
	logic [16:0] flash_addr, last_addr;
	logic [7:0] flash_wdata, flash_rdata, code_raw, code_data;
	int n_mismatch = 0;
	int tests_run = 0;
	int req_cycles = 0;
	int n;
	row_type rows [8] = '{
		'{`IDX_ADDR_LOW, 8'h00, 8'h5a, 8'h5a},
		'{`IDX_ADDR_HIGH, 8'h00, 8'ha5, 8'ha5},
		'{`IDX_ADDR_TOP, 8'h00, 8'h01, 8'h01},
		'{`IDX_DATA, 8'h00, 8'h3c, 8'h00},
		'{`IDX_BOUND_LO, 8'hff, 8'h10, 8'h10},
		'{`IDX_BOUND_HI, 8'h00, 8'h80, 8'h80},
		'{`IDX_GUARD_LO, 8'h00, 8'hff, 8'h00},
		'{`IDX_GUARD_HI, 8'h00, 8'h7f, 8'h00}
	};
	zone_type zones [5] = '{
		'{17'h0_0e12, 8'h02, 1'b1},
		'{17'h0_0f34, 8'h04, 1'b0},
		'{17'h0_8156, 8'h02, 1'b0},
		'{17'h0_8278, 8'h04, 1'b1},
		'{17'h1_009a, 8'h02, 1'b1}
	};
	logic [16:0] ga [4] = '{17'h0_5fff, 17'h0_6000, 17'h0_ffff, 17'h1_0000};

	always #2 clock = ~clock;
	always @(posedge clock) if (flash_req === 1'b1) req_cycles++;

	flash_access_protection uut (.clock(clock), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timed_write_unlock(timed_write_unlock), .flash_req(flash_req),
		.flash_op(flash_op), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
		.flash_ack(flash_ack), .flash_rdata(flash_rdata), .code_addr(code_addr),
		.code_raw(code_raw), .code_data(code_data));
	flash_array_model model (.clock(clock), .flash_req(flash_req), .flash_op(flash_op),
		.flash_addr(flash_addr), .flash_ack(flash_ack), .flash_rdata(flash_rdata),
		.code_addr(code_addr), .code_raw(code_raw), .last_op(last_op),
		.last_addr(last_addr));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	function automatic logic [7:0] pat(input logic [16:0] a);
		return a[7:0] ^ a[15:8] ^ {7'h00, a[16]} ^ 8'ha5;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rv = {prdata[31:1], prdata[0]};
		if (pslverr === 1'b1) rv = 32'hdead_0000;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic set_addr(input logic [16:0] a);
		apb(1'b1, `IDX_ADDR_LOW, a[7:0]);
		apb(1'b1, `IDX_ADDR_HIGH, a[15:8]);
		apb(1'b1, `IDX_ADDR_TOP, {7'h00, a[16]});
	endtask

	task automatic cmd(input logic [7:0] c);
		apb(1'b1, `IDX_COMMAND, c);
		do apb(1'b0, `IDX_STATUS, 8'h00); while (rv[`STAT_DONE_BIT] !== 1'b1);
	endtask

	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge clock);
		n_mismatch++;
		close_out();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		do_reset();
		foreach (rows[i]) begin
			apb(1'b0, rows[i].idx, 8'h00);
			chk(rv, {24'h00_0000, rows[i].rst});
			apb(1'b1, rows[i].idx, rows[i].wd);
			apb(1'b0, rows[i].idx, 8'h00);
			chk(rv, {24'h00_0000, rows[i].exp});
		end
		chk({24'h00_0000, flash_wdata}, 32'h0000_003c);
		apb(1'b0, 16'ha030, 8'h00);
		chk(rv, 32'hdead_0000);
		$display("register table done");
		foreach (zones[i]) begin
			set_addr(zones[i].a);
			n = req_cycles;
			cmd(zones[i].c);
			chk(rv, zones[i].f ? 32'h0000_0006 : 32'h0000_0004);
			chk({31'h0, req_cycles != n}, {31'h0, !zones[i].f});
			if (!zones[i].f) chk({last_op, last_addr}, {(zones[i].c == 8'h02) ? 2'h1 : 2'h2,
				zones[i].a});
		end
		$display("zone table done");
		do_reset();
		set_addr(17'h0_0800);
		n = req_cycles;
		cmd(8'h02);
		chk(rv, 32'h0000_0006);
		chk(req_cycles, n);
		cmd(8'h01);
		chk(rv, 32'h0000_0004);
		apb(1'b0, `IDX_DATA, 8'h00);
		chk(rv, {24'h00_0000, pat(17'h0_0800)});
		$display("reset protection done");
		timed_write_unlock <= 1'b1;
		apb(1'b1, `IDX_GUARD_HI, 8'h04);
		apb(1'b1, `IDX_GUARD_LO, 8'h20);
		apb(1'b1, `IDX_GUARD_LO, 8'h00);
		apb(1'b0, `IDX_GUARD_LO, 8'h00);
		chk(rv, 32'h0000_0020);
		apb(1'b0, `IDX_GUARD_HI, 8'h00);
		chk(rv, 32'h0000_0004);
		foreach (ga[i]) begin
			code_addr <= ga[i];
			repeat (2) @(posedge clock);
			chk(code_data, (ga[i] inside {[17'h0_6000:17'h0_ffff]}) ? 8'h00 :
				pat(ga[i]));
		end
		set_addr(17'h0_7000);
		cmd(8'h01);
		apb(1'b0, `IDX_DATA, 8'h00);
		chk(rv, 32'h0000_0000);
		$display("read guard done");
		do_reset();
		apb(1'b0, `IDX_GUARD_LO, 8'h00);
		chk(rv, 32'h0000_0000);
		code_addr <= 17'h0_6000;
		repeat (2) @(posedge clock);
		chk(code_data, pat(17'h0_6000));
		$display("guard reset done");
		close_out();
	end
endmodule

`default_nettype wire
